// [dma_err_pkg.sv]
package dma_err_pkg;

	// =====================================================================
	// Widths
	// =====================================================================
	localparam int ADDR_W       = 8;
	localparam int DATA_W       = 32;
	localparam int UPPER_CH     = 32;
	localparam int QUICK_CH     = 8;
	localparam int NUM_QUEUES   = 2;
	localparam int QCNT_W       = 5;
	localparam int TCC_CNT_W    = 7;
	localparam int CTRL_FLAGS   = 3;

	// =====================================================================
	// Register offsets
	// =====================================================================
	localparam logic [ADDR_W-1:0] OFF_UPPER_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_UPPER_CLEAR  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_QUICK_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_QUICK_CLEAR  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_CTRL_STATUS  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CTRL_CLEAR   = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_ERROR_EVALUATE_BIT         = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_WATERMARK    = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_QSTAT0       = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_QSTAT1       = 8'h24;

	// =====================================================================
	// Field positions
	// =====================================================================
	localparam int CTRL_Q0_BIT      = 0;
	localparam int CTRL_Q1_BIT      = 1;
	localparam int CTRL_TCC_BIT     = 16;
	localparam int ERROR_EVALUATE_BIT_BIT         = 0;
	localparam int WMSET_Q0_LSB     = 0;
	localparam int WMSET_Q1_LSB     = 8;
	localparam int QUEUE_STATUS_REGISTER_WM_LSB     = 8;
	localparam int QUEUE_STATUS_REGISTER_THR_BIT    = 24;

	// =====================================================================
	// Reset values and limits
	// =====================================================================
	localparam logic [DATA_W-1:0]    RST_ZERO      = 32'h0000_0000;
	localparam logic [QCNT_W-1:0]    RST_WATERMARK = 5'h10;
	localparam logic [TCC_CNT_W-1:0] TCC_MAX_OUT   = 7'h3F;

	// =====================================================================
	// Carriers
	// =====================================================================
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

	typedef struct packed {
		logic [QUICK_CH-1:0] event_hit;
		logic [QUICK_CH-1:0] serviced;
		logic [QUICK_CH-1:0] null_hit;
	} quick_ev_t;

endpackage : dma_err_pkg

// [err_flag_bank.sv]
`timescale 1ns/1ps
module err_flag_bank #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	output logic      [W-1:0] flags_q
);

	// =====================================================================
	// Sticky flags
	// =====================================================================
	// Set is ORed last so an event on the clear cycle survives
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= '0;
		end else begin
			flags_q <= (flags_q & ~clr_i) | set_i; // R16
		end
	end

endmodule : err_flag_bank

// [dma_error_status_regs.sv]
// How it works
// [R1] A one written to bit n of the upper clear register clears the missed flag of channel 32+n.
// [R2] While any error flag is still set, only a one written to the evaluate bit raises a further error pulse.
// [R3] A second quick event before the first is serviced sets that channel's quick missed flag.
// [R4] A quick event meeting a null parameter entry also sets the quick missed flag.
// [R5] A quick missed flag rising from an all-clear state raises the error pulse.
// [R6] Quick status is read only, bits 7-0 hold the flags, bits 31-8 read zero, reset zero.
// [R7] A quick flag stays set until a one is written to its bit of the quick clear register.
// [R8] A queue threshold flag sets whenever its queue count reaches or passes its watermark.
// [R9] Controller error bit 0 is queue 0, bit 1 is queue 1, bits 15-2 and 31-17 read zero.
// [R10] Bit 16 sets when outstanding completion-code requests exceed 63.
// [R11] Controller error flags stay set until a one is written to the matching clear bit.
// [R12] A controller error flag rising from an all-clear state raises the error pulse.
// [R13] A queue clear bit also reloads that queue's watermark field with its present count and clears its threshold flag.
// [R14] The error pulse repeats only on a change from all flags clear to some flag set, or on an evaluate write.
// [R15] Writing one to the evaluate bit pulses the error output if any flag is still set.
// [R16] A set and a clear on the same flag in one cycle leave the flag set.
`timescale 1ns/1ps
module dma_error_status_regs #(
	parameter int QCNT_W    = dma_err_pkg::QCNT_W,
	parameter int TCC_CNT_W = dma_err_pkg::TCC_CNT_W
) (
	input  wire logic                                sys_clk,
	input  wire logic                                rst_n,
	input  wire dma_err_pkg::reg_req_t               req,
	output logic [dma_err_pkg::DATA_W-1:0]           rdata_q,
	input  wire logic [dma_err_pkg::UPPER_CH-1:0]    upper_missed_set,
	input  wire dma_err_pkg::quick_ev_t              quick_ev,
	input  wire logic [QCNT_W-1:0]                   queue0_count,
	input  wire logic [QCNT_W-1:0]                   queue1_count,
	input  wire logic                                tcc_issue,
	input  wire logic                                tcc_return,
	output logic                                     error_irq
);

	// =====================================================================
	// Declarations
	// =====================================================================
	localparam int NQ = dma_err_pkg::NUM_QUEUES;
	localparam int QC = dma_err_pkg::QUICK_CH;

	logic [dma_err_pkg::UPPER_CH-1:0] upper_flags;
	logic [dma_err_pkg::UPPER_CH-1:0] upper_clr;
	logic [QC-1:0]                    quick_flags;
	logic [QC-1:0]                    quick_set;
	logic [QC-1:0]                    quick_clr;
	logic [QC-1:0]                    pending_q;
	logic [dma_err_pkg::CTRL_FLAGS-1:0] ctrl_flags;
	logic [dma_err_pkg::CTRL_FLAGS-1:0] ctrl_set;
	logic [dma_err_pkg::CTRL_FLAGS-1:0] ctrl_clr;
	logic [QCNT_W-1:0]                wm_setting_q [NQ];
	logic [QCNT_W-1:0]                wm_peak_q    [NQ];
	logic [QCNT_W-1:0]                qcount       [NQ];
	logic [NQ-1:0]                    thr_hit;
	logic [TCC_CNT_W-1:0]             tcc_out_q;
	logic                             tcc_over;
	logic                             any_err;
	logic                             any_prev_q;
	logic                             error_evaluate_bit_hit;
	logic                             irq_q;

	assign qcount[0] = queue0_count;
	assign qcount[1] = queue1_count;

	// =====================================================================
	// Address decode
	// =====================================================================
	function automatic logic wr_at(input dma_err_pkg::reg_req_t r,
	                               input logic [dma_err_pkg::ADDR_W-1:0] off);
		wr_at = r.wr && (r.addr == off);
	endfunction : wr_at

	function automatic logic [dma_err_pkg::DATA_W-1:0] clr_mask(
		input dma_err_pkg::reg_req_t r,
		input logic [dma_err_pkg::ADDR_W-1:0] off);
		clr_mask = wr_at(r, off) ? r.wdata : dma_err_pkg::RST_ZERO;
	endfunction : clr_mask

	// =====================================================================
	// Upper missed-event flags
	// =====================================================================
	assign upper_clr = clr_mask(req, dma_err_pkg::OFF_UPPER_CLEAR); // R1

	err_flag_bank #(
		.W (dma_err_pkg::UPPER_CH)
	) u_upper (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.set_i   (upper_missed_set),
		.clr_i   (upper_clr),
		.flags_q (upper_flags)
	);

	// =====================================================================
	// Quick-channel missed events
	// =====================================================================
	// A service in the same cycle retires the first event, so no miss
	genvar gq;
	generate
		for (gq = 0; gq < QC; gq++) begin : g_quick
			assign quick_set[gq] = (quick_ev.event_hit[gq] && pending_q[gq] // R3
			                        && !quick_ev.serviced[gq])
			                       || quick_ev.null_hit[gq]; // R4
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					pending_q[gq] <= 1'b0;
				end else if (quick_ev.event_hit[gq]) begin
					pending_q[gq] <= 1'b1;
				end else if (quick_ev.serviced[gq]) begin
					pending_q[gq] <= 1'b0;
				end
			end
		end
	endgenerate

	// Reserved bits 31-8 of the clear write are dropped here
	assign quick_clr = wr_at(req, dma_err_pkg::OFF_QUICK_CLEAR) // R7
	                   ? req.wdata[QC-1:0] : '0;

	err_flag_bank #(
		.W (QC)
	) u_quick (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.set_i   (quick_set),
		.clr_i   (quick_clr),
		.flags_q (quick_flags)
	);

	// =====================================================================
	// Queue thresholds and watermarks
	// =====================================================================
	genvar gw;
	generate
		for (gw = 0; gw < NQ; gw++) begin : g_queue
			localparam int WLSB = (gw == 0) ? dma_err_pkg::WMSET_Q0_LSB
			                                : dma_err_pkg::WMSET_Q1_LSB;
			assign thr_hit[gw] = (qcount[gw] >= wm_setting_q[gw]); // R8

			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					wm_setting_q[gw] <= dma_err_pkg::RST_WATERMARK;
				end else if (wr_at(req, dma_err_pkg::OFF_WATERMARK)) begin
					wm_setting_q[gw] <= req.wdata[WLSB +: QCNT_W];
				end
			end

			// Peak queue depth; a clear restarts it from the present count
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					wm_peak_q[gw] <= '0;
				end else if (ctrl_clr[gw]) begin
					wm_peak_q[gw] <= qcount[gw]; // R13
				end else if (qcount[gw] > wm_peak_q[gw]) begin
					wm_peak_q[gw] <= qcount[gw];
				end
			end
		end
	endgenerate

	// =====================================================================
	// Outstanding completion codes
	// =====================================================================
	// Saturates so a runaway issuer cannot wrap the count back under 63
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tcc_out_q <= '0;
		end else if (tcc_issue && !tcc_return && !(&tcc_out_q)) begin
			tcc_out_q <= tcc_out_q + 1'b1;
		end else if (tcc_return && !tcc_issue && (tcc_out_q != '0)) begin
			tcc_out_q <= tcc_out_q - 1'b1;
		end
	end

	assign tcc_over = (tcc_out_q > TCC_CNT_W'(dma_err_pkg::TCC_MAX_OUT)); // R10

	// =====================================================================
	// Controller error flags
	// =====================================================================
	assign ctrl_set = {tcc_over, thr_hit[1], thr_hit[0]}; // R8 R10
	assign ctrl_clr = {req.wdata[dma_err_pkg::CTRL_TCC_BIT] && // R11 R13
	                   wr_at(req, dma_err_pkg::OFF_CTRL_CLEAR),
	                   req.wdata[dma_err_pkg::CTRL_Q1_BIT] &&
	                   wr_at(req, dma_err_pkg::OFF_CTRL_CLEAR),
	                   req.wdata[dma_err_pkg::CTRL_Q0_BIT] &&
	                   wr_at(req, dma_err_pkg::OFF_CTRL_CLEAR)};

	err_flag_bank #(
		.W (dma_err_pkg::CTRL_FLAGS)
	) u_ctrl (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.set_i   (ctrl_set),
		.clr_i   (ctrl_clr),
		.flags_q (ctrl_flags)
	);

	// =====================================================================
	// Error interrupt
	// =====================================================================
	// One pulse per rise of the combined flag; evaluate forces a repeat while any flag is set
	assign any_err  = (|upper_flags) || (|quick_flags) || (|ctrl_flags);
	assign error_evaluate_bit_hit = wr_at(req, dma_err_pkg::OFF_ERROR_EVALUATE_BIT) && req.wdata[dma_err_pkg::ERROR_EVALUATE_BIT_BIT];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			any_prev_q <= 1'b0;
		end else begin
			any_prev_q <= any_err;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (any_err && !any_prev_q) // R2 R5 R12 R14
			         || (error_evaluate_bit_hit && any_err); // R15
		end
	end

	assign error_irq = irq_q;

	// =====================================================================
	// Read data
	// =====================================================================
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= dma_err_pkg::RST_ZERO;
		end else if (req.rd) begin
			rdata_q <= dma_err_pkg::RST_ZERO;
			if (req.addr == dma_err_pkg::OFF_UPPER_STATUS) begin
				rdata_q <= upper_flags;
			end else if (req.addr == dma_err_pkg::OFF_QUICK_STATUS) begin
				rdata_q[QC-1:0] <= quick_flags; // R6
			end else if (req.addr == dma_err_pkg::OFF_CTRL_STATUS) begin
				rdata_q[dma_err_pkg::CTRL_Q0_BIT]  <= ctrl_flags[0]; // R9
				rdata_q[dma_err_pkg::CTRL_Q1_BIT]  <= ctrl_flags[1];
				rdata_q[dma_err_pkg::CTRL_TCC_BIT] <= ctrl_flags[2];
			end else if (req.addr == dma_err_pkg::OFF_WATERMARK) begin
				rdata_q[dma_err_pkg::WMSET_Q0_LSB +: QCNT_W] <= wm_setting_q[0];
				rdata_q[dma_err_pkg::WMSET_Q1_LSB +: QCNT_W] <= wm_setting_q[1];
			end else if (req.addr == dma_err_pkg::OFF_QSTAT0) begin
				rdata_q[dma_err_pkg::QUEUE_STATUS_REGISTER_WM_LSB +: QCNT_W] <= wm_peak_q[0];
				rdata_q[dma_err_pkg::QUEUE_STATUS_REGISTER_THR_BIT]          <= ctrl_flags[0];
			end else if (req.addr == dma_err_pkg::OFF_QSTAT1) begin
				rdata_q[dma_err_pkg::QUEUE_STATUS_REGISTER_WM_LSB +: QCNT_W] <= wm_peak_q[1];
				rdata_q[dma_err_pkg::QUEUE_STATUS_REGISTER_THR_BIT]          <= ctrl_flags[1];
			end
		end
	end

	// =====================================================================
	// Assertions
	// =====================================================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_quick_miss(int ch);
		quick_ev.event_hit[ch] && pending_q[ch] && !quick_ev.serviced[ch];
	endsequence

	sequence s_error_evaluate_bit_write;
		req.wr && req.addr == dma_err_pkg::OFF_ERROR_EVALUATE_BIT && req.wdata[0];
	endsequence

	a_upper_clear_one: assert property ( // R1
		wr_at(req, dma_err_pkg::OFF_UPPER_CLEAR)
		|=> (upper_flags & $past(req.wdata) & ~$past(upper_missed_set)) == '0)
		else $error("upper flag survived a clear write");

	a_upper_zero_keep: assert property ( // R1
		wr_at(req, dma_err_pkg::OFF_UPPER_CLEAR)
		|=> (upper_flags & $past(upper_flags & ~req.wdata))
		    == $past(upper_flags & ~req.wdata))
		else $error("upper flag lost on a zero write");

	a_quick_second_evt: assert property ( // R3
		s_quick_miss(5) |=> quick_flags[5])
		else $error("second quick event not flagged");

	a_quick_null_hit: assert property ( // R4
		(quick_ev.null_hit != '0) |=> ((quick_flags & $past(quick_ev.null_hit))
		                               == $past(quick_ev.null_hit)))
		else $error("null entry not flagged");

	a_quick_read_res: assert property ( // R6
		req.rd && req.addr == dma_err_pkg::OFF_QUICK_STATUS
		|=> rdata_q[31:8] == '0 && rdata_q[7:0] == $past(quick_flags))
		else $error("quick status read wrong");

	a_quick_sticky: assert property ( // R7
		quick_flags[2] && !(wr_at(req, dma_err_pkg::OFF_QUICK_CLEAR) && req.wdata[2])
		|=> quick_flags[2])
		else $error("quick flag dropped without a clear");

	a_thresh_set: assert property ( // R8
		queue0_count >= wm_setting_q[0] |=> ctrl_flags[0])
		else $error("queue threshold not flagged");

	a_ctrl_read_res: assert property ( // R9
		req.rd && req.addr == dma_err_pkg::OFF_CTRL_STATUS
		|=> rdata_q[15:2] == '0 && rdata_q[31:17] == '0
		    && rdata_q[16] == $past(ctrl_flags[2]))
		else $error("controller status read wrong");

	a_tcc_overflow: assert property ( // R10
		tcc_out_q == 7'h3F && tcc_issue && !tcc_return ##1 1'b1 |=> ctrl_flags[2])
		else $error("completion code overflow not flagged");

	a_ctrl_sticky: assert property ( // R11
		ctrl_flags[2] && !ctrl_clr[2] |=> ctrl_flags[2])
		else $error("controller flag dropped without a clear");

	a_peak_cleared: assert property ( // R13
		ctrl_clr[1] |=> wm_peak_q[1] == $past(queue1_count))
		else $error("watermark field not cleared");

	a_irq_on_rise: assert property ( // R5 R12 R14
		!any_err ##1 any_err |=> error_irq)
		else $error("error pulse missed on first flag");

	a_irq_quiet: assert property ( // R2
		any_err [*3] and (!error_evaluate_bit_hit) [*3] |=> !error_irq)
		else $error("error pulse repeated while flags set");

	a_error_evaluate_bit_pulse: assert property ( // R15
		s_error_evaluate_bit_write and any_err |=> error_irq ##1 (!error_irq || $past(error_evaluate_bit_hit)))
		else $error("evaluate write gave no pulse");

	a_set_beats_clear: assert property ( // R16
		quick_ev.null_hit[5] && quick_clr[5] |=> quick_flags[5])
		else $error("clear won over a same-cycle set");

	a_ctrl_set_wins: assert property ( // R16
		ctrl_set[0] && ctrl_clr[0] |=> ctrl_flags[0])
		else $error("controller clear won over a live threshold");

	a_error_evaluate_bit_zero_quiet: assert property ( // R15
		wr_at(req, dma_err_pkg::OFF_ERROR_EVALUATE_BIT) && !req.wdata[dma_err_pkg::ERROR_EVALUATE_BIT_BIT] && any_prev_q
		|=> !error_irq)
		else $error("zero evaluate write gave a pulse");

endmodule : dma_error_status_regs

// [dma_error_status_regs_test.sv]
`timescale 1ns/1ps
module dma_error_status_regs_test;

	// =====================================================================
	// Signals
	// =====================================================================
	logic                                 sys_clk = 1'h0;
	logic                                 rst_n   = 1'h0;
	dma_err_pkg::reg_req_t                req     = '0;
	logic [dma_err_pkg::DATA_W-1:0]       rdata_q;
	logic [dma_err_pkg::UPPER_CH-1:0]     upper_missed_set = '0;
	dma_err_pkg::quick_ev_t               quick_ev = '0;
	logic [4:0]                           queue0_count = 5'h00;
	logic [4:0]                           queue1_count = 5'h00;
	logic                                 tcc_issue  = 1'h0;
	logic                                 tcc_return = 1'h0;
	logic                                 error_irq;
	logic                                 rd_pend = 1'h0;
	logic [31:0]                          exp_q[$];
	logic [31:0]                          mask_q[$];
	logic [31:0]                          pat;
	logic [31:0]                          msk;
	logic [31:0]                          rmask;
	dma_err_pkg::quick_ev_t               qe;
	int                                   error_cnt = 0;
	int                                   cmp_count = 0;
	int                                   irq_seen  = 0;
	int                                   irq_exp   = 0;
	int                                   cyc       = 0;

	dma_error_status_regs i_dut (
		.sys_clk          (sys_clk),
		.rst_n            (rst_n),
		.req              (req),
		.rdata_q          (rdata_q),
		.upper_missed_set (upper_missed_set),
		.quick_ev         (quick_ev),
		.queue0_count     (queue0_count),
		.queue1_count     (queue1_count),
		.tcc_issue        (tcc_issue),
		.tcc_return       (tcc_return),
		.error_irq        (error_irq)
	);

	always #5 sys_clk = ~sys_clk;

	// =====================================================================
	// Checking and closing
	// =====================================================================
	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		cmp_count++;
		if (seen !== expd) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask : check

	task automatic stop_test;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	// Ceiling well above the few hundred cycles the sequence needs
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt++;
			stop_test();
		end
	end

	// =====================================================================
	// Monitor: read data lands in the cycle after the strobe and holds until the next read
	// =====================================================================
	always @(posedge sys_clk) begin
		rd_pend <= req.rd;
		if (error_irq === 1'h1) begin
			irq_seen <= irq_seen + 1;
		end
	end

	always @(negedge sys_clk) begin
		if (rd_pend) begin
			rmask = mask_q.pop_front();
			check(rdata_q & rmask, exp_q.pop_front());
		end
	end

	// =====================================================================
	// Bus and event tasks
	// =====================================================================
	task automatic wr(input logic [dma_err_pkg::ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'h1;
		@(posedge sys_clk);
		req.wr    <= 1'h0;
	endtask : wr

	task automatic rd(input logic [dma_err_pkg::ADDR_W-1:0] a, input logic [31:0] e,
			input logic [31:0] m);
		exp_q.push_back(e & m);
		mask_q.push_back(m);
		@(posedge sys_clk);
		req.addr <= a;
		req.rd   <= 1'h1;
		@(posedge sys_clk);
		req.rd   <= 1'h0;
	endtask : rd

	task automatic ev(input dma_err_pkg::quick_ev_t q);
		@(posedge sys_clk);
		quick_ev <= q;
		@(posedge sys_clk);
		quick_ev <= '0;
	endtask : ev

	// Irq lands two cycles after its cause, so let it settle first
	task automatic chk_irq;
		repeat (4) @(posedge sys_clk);
		check(irq_seen, irq_exp);
	endtask : chk_irq

	// =====================================================================
	// Sequence
	// =====================================================================
	initial begin
		pat = $urandom(32'h3E25);
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'h1;
		rd(dma_err_pkg::OFF_QUICK_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(dma_err_pkg::OFF_CTRL_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(dma_err_pkg::OFF_QUICK_CLEAR, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
		// Upper missed flags: random set, random clear mask
		pat = $urandom() | 32'h0000_0001;
		msk = $urandom();
		@(posedge sys_clk);
		upper_missed_set <= pat;
		@(posedge sys_clk);
		upper_missed_set <= '0;
		irq_exp++;
		rd(dma_err_pkg::OFF_UPPER_STATUS, pat, 32'hFFFF_FFFF);
		wr(dma_err_pkg::OFF_UPPER_CLEAR, msk);
		rd(dma_err_pkg::OFF_UPPER_STATUS, pat & ~msk, 32'hFFFF_FFFF);
		wr(dma_err_pkg::OFF_UPPER_CLEAR, 32'hFFFF_FFFF);
		rd(dma_err_pkg::OFF_UPPER_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
		chk_irq();
		// Every quick channel through a null entry, cleared in between
		for (int i = 0; i < dma_err_pkg::QUICK_CH; i++) begin
			qe = '0;
			qe.null_hit[i] = 1'h1;
			ev(qe);
			irq_exp++;
			rd(dma_err_pkg::OFF_QUICK_STATUS, 32'h1 << i, 32'hFFFF_FFFF);
			wr(dma_err_pkg::OFF_QUICK_CLEAR, 32'h1 << i);
			chk_irq();
		end
		// Null on 3, then a double event on 5 while 3 still set
		qe = '0;
		qe.null_hit[3] = 1'h1;
		ev(qe);
		irq_exp++;
		qe = '0;
		qe.event_hit[5] = 1'h1;
		ev(qe);
		ev(qe);
		// Serviced between events: no miss on 6
		qe = '0;
		qe.event_hit[6] = 1'h1;
		ev(qe);
		qe = '0;
		qe.serviced[6] = 1'h1;
		ev(qe);
		qe = '0;
		qe.event_hit[6] = 1'h1;
		ev(qe);
		rd(dma_err_pkg::OFF_QUICK_STATUS, 32'h0000_0028, 32'hFFFF_FFFF);
		chk_irq();
		wr(dma_err_pkg::OFF_QUICK_CLEAR, 32'hFFFF_FF08);
		rd(dma_err_pkg::OFF_QUICK_STATUS, 32'h0000_0020, 32'hFFFF_FFFF);
		// Set and clear on channel 5 in one cycle: set wins
		@(posedge sys_clk);
		quick_ev.null_hit[5] <= 1'h1;
		req.addr  <= dma_err_pkg::OFF_QUICK_CLEAR;
		req.wdata <= 32'h0000_0020;
		req.wr    <= 1'h1;
		@(posedge sys_clk);
		quick_ev <= '0;
		req.wr   <= 1'h0;
		rd(dma_err_pkg::OFF_QUICK_STATUS, 32'h0000_0020, 32'hFFFF_FFFF);
		wr(dma_err_pkg::OFF_QUICK_CLEAR, 32'h0000_00FF);
		rd(dma_err_pkg::OFF_QUICK_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
		chk_irq();
		// Queue thresholds: watermark 3 and 4, counts at and below them
		wr(dma_err_pkg::OFF_WATERMARK, 32'h0000_0403);
		rd(dma_err_pkg::OFF_WATERMARK, 32'h0000_0403, 32'h0000_1F1F);
		@(posedge sys_clk);
		queue0_count <= 5'h03;
		queue1_count <= 5'h03;
		irq_exp++;
		rd(dma_err_pkg::OFF_CTRL_STATUS, 32'h0000_0001, 32'hFFFF_FFFF);
		@(posedge sys_clk);
		queue1_count <= 5'h04;
		rd(dma_err_pkg::OFF_CTRL_STATUS, 32'h0000_0003, 32'hFFFF_FFFF);
		rd(dma_err_pkg::OFF_QSTAT1, 32'h0100_0000, 32'h0100_0000);
		wr(dma_err_pkg::OFF_CTRL_CLEAR, 32'h0000_0001);
		rd(dma_err_pkg::OFF_CTRL_STATUS, 32'h0000_0003, 32'hFFFF_FFFF);
		@(posedge sys_clk);
		queue0_count <= 5'h02;
		queue1_count <= 5'h03;
		wr(dma_err_pkg::OFF_CTRL_CLEAR, 32'h0000_0003);
		rd(dma_err_pkg::OFF_CTRL_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(dma_err_pkg::OFF_QSTAT0, 32'h0000_0200, 32'h0100_1F00);
		chk_irq();
		// Completion codes: 63 outstanding is fine, the 64th flags
		@(posedge sys_clk);
		tcc_issue <= 1'h1;
		repeat (63) @(posedge sys_clk);
		tcc_issue <= 1'h0;
		rd(dma_err_pkg::OFF_CTRL_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
		@(posedge sys_clk);
		tcc_issue <= 1'h1;
		@(posedge sys_clk);
		tcc_issue  <= 1'h0;
		tcc_return <= 1'h1;
		irq_exp++;
		repeat (64) @(posedge sys_clk);
		tcc_return <= 1'h0;
		rd(dma_err_pkg::OFF_CTRL_STATUS, 32'h0001_0000, 32'hFFFF_FFFF);
		chk_irq();
		// Evaluate: one pulse with a flag still set, none for a zero write
		wr(dma_err_pkg::OFF_ERROR_EVALUATE_BIT, 32'h0000_0001);
		irq_exp++;
		wr(dma_err_pkg::OFF_ERROR_EVALUATE_BIT, 32'h0000_0000);
		chk_irq();
		wr(dma_err_pkg::OFF_CTRL_CLEAR, 32'h0001_0000);
		rd(dma_err_pkg::OFF_CTRL_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
		wr(dma_err_pkg::OFF_ERROR_EVALUATE_BIT, 32'h0000_0001);
		chk_irq();
		stop_test();
	end

endmodule : dma_error_status_regs_test
